// ===== sim/urhp_dev_model.sv
// downstream device model: drives attach, overcurrent and wake pins
`timescale 1ns/1ps
module urhp_dev_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic attach_req,
    input wire logic oc_req,
    input wire logic wake_req,
    input wire logic port_reset_drive,
    input wire logic port_resume_drive,
    output logic attach_pin,
    output logic overcurrent_pin,
    output logic wake_pin,
    output logic [31:0] reset_len,
    output logic [31:0] resume_len
);
    logic [31:0] rst_cnt_q;
    logic [31:0] res_cnt_q;

    // pins move on the clock; wake stops once the host drives resume itself
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            attach_pin <= 1'b0;
            overcurrent_pin <= 1'b0;
            wake_pin <= 1'b0;
        end
        else
        begin
            attach_pin <= attach_req;
            overcurrent_pin <= oc_req;
            wake_pin <= wake_req & ~port_resume_drive;
        end
    end

    // measures how many cycles each drive stands, latched at its fall
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rst_cnt_q <= '0;
            res_cnt_q <= '0;
            reset_len <= '0;
            resume_len <= '0;
        end
        else
        begin
            rst_cnt_q <= port_reset_drive ? rst_cnt_q + 1 : '0;
            res_cnt_q <= port_resume_drive ? res_cnt_q + 1 : '0;
            if (!port_reset_drive && rst_cnt_q != 0)
                reset_len <= rst_cnt_q;
            if (!port_resume_drive && res_cnt_q != 0)
                resume_len <= res_cnt_q;
        end
    end
endmodule

// ===== sim/urhp_port_test.sv
// self-checking bench for the root hub port reset and suspend block
`timescale 1ns/1ps
module urhp_port_test
    import urhp_pkg::*;
;
    localparam int RC = 20;
    localparam int RS = 30;
    localparam logic [31:0] A = 32'h1;
    localparam logic [31:0] EN = 32'h2;
    localparam logic [31:0] SU = 32'h4;
    localparam logic [31:0] OC = 32'h8;
    localparam logic [31:0] RE = 32'h10;
    localparam logic [31:0] AC = 32'h0001_0000;
    localparam logic [31:0] SC = 32'h0004_0000;
    localparam logic [31:0] RC_F = 32'h0010_0000;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} urhp_row_t;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [URHP_ADDR_W-1:0] paddr = '0;
    logic [URHP_DATA_W-1:0] pwdata = '0;
    logic [URHP_DATA_W-1:0] prdata;
    logic pready, pslverr, attach_pin, overcurrent_pin, wake_pin;
    logic hc_resume_state = 1'b0;
    logic pce = 1'b1;
    logic attach_req = 1'b0;
    logic oc_req = 1'b0;
    logic wake_req = 1'b0;
    logic port_reset_drive, port_resume_drive, port_enabled, resume_to_hc;
    logic [31:0] reset_len, resume_len, r;
    logic e;
    int n_mismatch = 0;
    int compares = 0;
    int n_wake = 0;
    int cyc = 0;
    urhp_row_t rows [7];

    urhp_port #(.RESET_CYCLES(RC), .RESUME_CYCLES(RS)) dut (.pclk(pclk), .presetn(presetn), .pce(pce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .attach_pin(attach_pin), .overcurrent_pin(overcurrent_pin),
        .wake_pin(wake_pin), .hc_resume_state(hc_resume_state), .port_reset_drive(port_reset_drive),
        .port_resume_drive(port_resume_drive), .port_enabled(port_enabled), .resume_to_hc(resume_to_hc));
    urhp_dev_model dev (.pclk(pclk), .presetn(presetn), .attach_req(attach_req), .oc_req(oc_req),
        .wake_req(wake_req), .port_reset_drive(port_reset_drive), .port_resume_drive(port_resume_drive),
        .attach_pin(attach_pin), .overcurrent_pin(overcurrent_pin), .wake_pin(wake_pin),
        .reset_len(reset_len), .resume_len(resume_len));

    always #4 pclk = ~pclk;

    // upstream resume pulses, and a ceiling on run length
    always @(posedge pclk)
    begin
        if (resume_to_hc === 1'b1)
            n_wake++;
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
        compares++;
        if (got !== x)
        begin
            $display("Error %s expected %h seen %h", nm, x, got);
            n_mismatch++;
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle count assumed; only the bench ceiling ends a hung wait
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic st(input logic [31:0] x);
        apb(1'b0, URHP_OFS_STATUS, '0);
        chk("status", x, r);
    endtask

    task automatic wr(input logic [31:0] d);
        apb(1'b1, URHP_OFS_STATUS, d);
    endtask

    // bounded wait for reset or resume signalling to end
    task automatic wait_idle();
        int n;
        n = 0;
        // one edge first, so a drive launched on the write edge is seen
        do
        begin
            @(posedge pclk);
            n++;
        end
        while ((port_reset_drive | port_resume_drive) === 1'b1 && n < 200);
    endtask

    initial
    begin
        rows[0] = '{1'b0, URHP_OFS_CONFIG, 32'h0, 32'h1, 1'b0};
        rows[1] = '{1'b0, URHP_OFS_STATUS, 32'h0, 32'h0, 1'b0};
        rows[2] = '{1'b1, URHP_OFS_CONFIG, 32'h0, 32'h0, 1'b0};
        rows[3] = '{1'b0, URHP_OFS_CONFIG, 32'h0, 32'h0, 1'b0};
        rows[4] = '{1'b1, URHP_OFS_CONFIG, 32'h1, 32'h0, 1'b0};
        rows[5] = '{1'b0, 8'h08, 32'h0, 32'h0, 1'b1};
        rows[6] = '{1'b1, 8'h0C, 32'hFFFF_FFFF, 32'h0, 1'b1};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i])
        begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk("row data", rows[i].x, r);
            chk("row err", {31'h0, rows[i].e}, {31'h0, e});
        end
        // no device: reset and suspend requests only flag the attach change
        wr(RE);
        st(AC);
        wr(SU);
        st(AC);
        wr(AC);
        attach_req <= 1'b1;
        repeat (8) @(posedge pclk);
        st(A | AC);
        wr(AC);
        wr(32'h0);
        st(A);
        wr(RE);
        @(negedge pclk);
        chk("reset drive", 32'h1, {31'h0, port_reset_drive});
        st(A | RE);
        wait_idle();
        st(A | EN | RC_F);
        chk("reset length", RC + 1, reset_len);
        chk("port enabled", 32'h1, {31'h0, port_enabled});
        wr(RC_F);
        oc_req <= 1'b1;
        repeat (8) @(posedge pclk);
        st(A | EN | OC);
        apb(1'b1, URHP_OFS_CONFIG, 32'h0);
        repeat (4) @(posedge pclk);
        st(A | EN);
        apb(1'b1, URHP_OFS_CONFIG, 32'h1);
        oc_req <= 1'b0;
        repeat (8) @(posedge pclk);
        st(A | EN);
        // resume command while not suspended must do nothing
        wr(OC);
        @(negedge pclk);
        chk("resume idle", 32'h0, {31'h0, port_resume_drive});
        wr(SU);
        st(A | EN | SU);
        wr(32'h0);
        @(negedge pclk);
        chk("resume on zero", 32'h0, {31'h0, port_resume_drive});
        wr(OC);
        @(negedge pclk);
        chk("resume drive", 32'h1, {31'h0, port_resume_drive});
        st(A | EN | SU);
        wait_idle();
        st(A | EN | SC);
        chk("resume length", RS + 1, resume_len);
        chk("wake count sw", 32'h0, n_wake);
        wr(SC);
        // device-initiated resume from suspend
        wr(SU);
        wake_req <= 1'b1;
        repeat (6) @(posedge pclk);
        wake_req <= 1'b0;
        wait_idle();
        chk("wake count", 32'h1, n_wake);
        st(A | EN | SC);
        wr(SC);
        wr(SU);
        hc_resume_state <= 1'b1;
        repeat (2) @(posedge pclk);
        hc_resume_state <= 1'b0;
        st(A | EN);
        wr(SU);
        wr(RE);
        // clock enable low freezes the reset interval for five edges
        pce <= 1'b0;
        repeat (5) @(posedge pclk);
        pce <= 1'b1;
        wait_idle();
        st(A | EN | RC_F);
        chk("frozen reset length", RC + 6, reset_len);
        wr(RC_F);
        // detach while suspended drops everything
        wr(SU);
        attach_req <= 1'b0;
        repeat (8) @(posedge pclk);
        st(AC);
        chk("port enabled", 32'h0, {31'h0, port_enabled});
        wr(AC);
        wr(SU);
        st(AC);
        stop_test();
    end
endmodule

// ===== src/urhp_pkg.sv
// shared constants and types for the root hub port reset and suspend block
package urhp_pkg;
    // register byte offsets on the apb window
    localparam logic [7:0] URHP_OFS_STATUS = 8'h00;
    localparam logic [7:0] URHP_OFS_CONFIG = 8'h04;
    // status read bits and command write bits of the status register
    localparam int URHP_BIT_ATTACHED = 0;
    localparam int URHP_BIT_ENABLED = 1;
    localparam int URHP_BIT_SUSPEND = 2;
    localparam int URHP_BIT_OVERCUR = 3;
    localparam int URHP_BIT_RESET = 4;
    localparam int URHP_BIT_ATTACH_CHG = 16;
    localparam int URHP_BIT_SUSP_CHG = 18;
    localparam int URHP_BIT_RESET_CHG = 20;
    // config register: per-port overcurrent reporting supported
    localparam int URHP_BIT_OC_EN = 0;
    localparam logic URHP_OC_EN_RST = 1'b1;
    // timing, clock rate in kHz, times in ms
    localparam int URHP_CLK_KHZ = 125000;
    localparam int URHP_T_RESET_MS = 10;
    localparam int URHP_T_RESUME_MS = 20;
    localparam int URHP_RESET_CYCLES = URHP_T_RESET_MS * URHP_CLK_KHZ;
    localparam int URHP_RESUME_CYCLES = URHP_T_RESUME_MS * URHP_CLK_KHZ;
    localparam int URHP_TMR_W = 22;
    localparam int URHP_DATA_W = 32;
    localparam int URHP_ADDR_W = 8;
    // port sequencing states
    typedef enum logic [1:0]
    {
        PS_IDLE = 2'b00,
        PS_RESET = 2'b01,
        PS_SUSPENDED = 2'b10,
        PS_RESUMING = 2'b11
    } urhp_state_t;
    // status bits as seen by software
    typedef struct packed
    {
        logic reset_done_change;
        logic suspend_done_change;
        logic attach_change;
        logic port_reset_active;
        logic port_overcurrent_flag;
        logic port_suspended;
        logic port_enabled;
        logic device_attached;
    } urhp_status_t;
endpackage

// ===== src/urhp_port.sv
// root hub port reset, overcurrent and suspend control behind an apb slave
// How it works
// - writing one to set-reset raises reset status and drives reset signaling meanwhile
// - reset status clears in the same edge the reset-done change flag rises
// - writing zero to set-reset leaves reset status alone
// - set-reset with no device attached only raises the attach change flag
// - overcurrent flag follows the synchronised overcurrent input
// - overcurrent flag stays zero when per-port reporting is not supported
// - writing one to overcurrent position starts resume, only while suspended
// - set-suspend sets suspend status; held through suspend and resume
// - suspend status clears as the suspend-done change flag rises after resume
// - suspend status is never set without an attached device
// - suspend clears when a port reset starts or on host controller resume state
// - upstream resume from a suspended device is passed to the host controller
// - attached status reports whether a device is on the port
`timescale 1ns/1ps
module urhp_port
    import urhp_pkg::*;
#(
    parameter int RESET_CYCLES = URHP_RESET_CYCLES,
    parameter int RESUME_CYCLES = URHP_RESUME_CYCLES
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [URHP_ADDR_W-1:0] paddr,
    input wire logic [URHP_DATA_W-1:0] pwdata,
    output logic [URHP_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic attach_pin,
    input wire logic overcurrent_pin,
    input wire logic wake_pin,
    input wire logic hc_resume_state,
    output logic port_reset_drive,
    output logic port_resume_drive,
    output logic port_enabled,
    output logic resume_to_hc
);
    localparam logic [URHP_TMR_W-1:0] RST_CNT = URHP_TMR_W'(RESET_CYCLES);
    localparam logic [URHP_TMR_W-1:0] RSM_CNT = URHP_TMR_W'(RESUME_CYCLES);

    if (RESET_CYCLES < 1 || RESET_CYCLES >= (1 << URHP_TMR_W))
    begin : g_bad_reset
        $error("urhp_port: reset interval does not fit the timer");
    end
    if (RESUME_CYCLES < 1 || RESUME_CYCLES >= (1 << URHP_TMR_W))
    begin : g_bad_resume
        $error("urhp_port: resume interval does not fit the timer");
    end

    // address match for one register word
    function automatic logic urhp_hit(input logic [URHP_ADDR_W-1:0] a, input logic [URHP_ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction

    logic att_s, oc_s, wake_s;
    urhp_state_t state_q, state_d;
    urhp_status_t sts;
    logic att_q, att_d, oc_q, oc_d, oc_en_q, oc_en_d;
    logic att_chg_q, att_chg_d, susp_chg_q, susp_chg_d, rst_chg_q, rst_chg_d;
    logic en_d, wake_d, rst_drv_d, rsm_drv_d;
    logic att_chg_set, susp_chg_set, rst_chg_set;
    logic tmr_load, tmr_stop, tmr_done;
    logic [URHP_TMR_W-1:0] tmr_count;
    logic [URHP_DATA_W-1:0] rd_word, prdata_d;
    logic pready_d, pslverr_d;
    logic acc, sts_wr, cfg_wr;
    logic cmd_reset, cmd_susp, cmd_resume;

    // pins come from outside the clock domain
    urhp_sync #(.W(3)) u_sync
    (
        .pclk(pclk),
        .presetn(presetn),
        .pce(pce),
        .d({attach_pin, overcurrent_pin, wake_pin}),
        .q({att_s, oc_s, wake_s})
    );

    // one timer serves both reset and resume, they never overlap
    urhp_timer #(.W(URHP_TMR_W)) u_timer
    (
        .pclk(pclk),
        .presetn(presetn),
        .pce(pce),
        .load(tmr_load),
        .count(tmr_count),
        .stop(tmr_stop),
        .expired(tmr_done)
    );

    // apb decode; a write lands on the edge that sees pready high
    assign acc = psel & penable & pready;
    assign sts_wr = acc & pwrite & urhp_hit(paddr, URHP_OFS_STATUS);
    assign cfg_wr = acc & pwrite & urhp_hit(paddr, URHP_OFS_CONFIG);
    assign cmd_reset = sts_wr & pwdata[URHP_BIT_RESET];
    assign cmd_susp = sts_wr & pwdata[URHP_BIT_SUSPEND];
    assign cmd_resume = sts_wr & pwdata[URHP_BIT_OVERCUR];

    // status view shared by read mux and assertions
    always_comb
    begin
        sts = '0;
        sts.reset_done_change = rst_chg_q;
        sts.suspend_done_change = susp_chg_q;
        sts.attach_change = att_chg_q;
        sts.port_reset_active = (state_q == PS_RESET);
        sts.port_overcurrent_flag = oc_q;
        sts.port_suspended = (state_q == PS_SUSPENDED) || (state_q == PS_RESUMING);
        sts.port_enabled = port_enabled;
        sts.device_attached = att_q;
    end

    // port sequencer; disconnect overrides every other event
    always_comb
    begin
        state_d = state_q;
        tmr_load = 1'b0;
        tmr_stop = 1'b0;
        tmr_count = RST_CNT;
        att_chg_set = (att_s != att_q);
        rst_chg_set = 1'b0;
        susp_chg_set = 1'b0;
        en_d = port_enabled;
        wake_d = 1'b0;
        if (!att_q)
        begin
            state_d = PS_IDLE;
            tmr_stop = 1'b0 | (state_q != PS_IDLE);
            en_d = 1'b0;
            if (cmd_reset || cmd_susp)
            begin
                att_chg_set = 1'b1;
            end
        end
        else
        begin
            case (state_q)
                PS_IDLE:
                begin
                    if (cmd_reset)
                    begin
                        state_d = PS_RESET;
                        tmr_load = 1'b1;
                    end
                    else if (cmd_susp)
                    begin
                        state_d = PS_SUSPENDED;
                    end
                end
                PS_RESET:
                begin
                    if (tmr_done)
                    begin
                        state_d = PS_IDLE;
                        rst_chg_set = 1'b1;
                        en_d = 1'b1;
                    end
                end
                PS_SUSPENDED:
                begin
                    if (cmd_reset)
                    begin
                        state_d = PS_RESET;
                        tmr_load = 1'b1;
                    end
                    else if (hc_resume_state)
                    begin
                        state_d = PS_IDLE;
                    end
                    else if (cmd_resume || wake_s)
                    begin
                        state_d = PS_RESUMING;
                        tmr_load = 1'b1;
                        tmr_count = RSM_CNT;
                        wake_d = wake_s;
                    end
                end
                PS_RESUMING:
                begin
                    if (cmd_reset)
                    begin
                        state_d = PS_RESET;
                        tmr_load = 1'b1;
                    end
                    else if (hc_resume_state)
                    begin
                        state_d = PS_IDLE;
                        tmr_stop = 1'b1;
                    end
                    else if (tmr_done)
                    begin
                        state_d = PS_IDLE;
                        susp_chg_set = 1'b1;
                        en_d = 1'b1;
                    end
                end
                default:
                begin
                    state_d = PS_IDLE;
                    tmr_stop = 1'b1;
                end
            endcase
        end
        rst_drv_d = (state_d == PS_RESET);
        rsm_drv_d = (state_d == PS_RESUMING);
    end

    // flags and inputs; a set in the clearing cycle wins
    always_comb
    begin
        att_d = att_s;
        oc_d = oc_s & oc_en_q;
        oc_en_d = cfg_wr ? pwdata[URHP_BIT_OC_EN] : oc_en_q;
        att_chg_d = (att_chg_q & ~(sts_wr & pwdata[URHP_BIT_ATTACH_CHG])) | att_chg_set;
        susp_chg_d = (susp_chg_q & ~(sts_wr & pwdata[URHP_BIT_SUSP_CHG])) | susp_chg_set;
        rst_chg_d = (rst_chg_q & ~(sts_wr & pwdata[URHP_BIT_RESET_CHG])) | rst_chg_set;
    end

    // read mux and answer; one wait state keeps every bus output registered
    always_comb
    begin
        rd_word = '0;
        rd_word[URHP_BIT_ATTACHED] = sts.device_attached;
        rd_word[URHP_BIT_ENABLED] = sts.port_enabled;
        rd_word[URHP_BIT_SUSPEND] = sts.port_suspended;
        rd_word[URHP_BIT_OVERCUR] = sts.port_overcurrent_flag;
        rd_word[URHP_BIT_RESET] = sts.port_reset_active;
        rd_word[URHP_BIT_ATTACH_CHG] = sts.attach_change;
        rd_word[URHP_BIT_SUSP_CHG] = sts.suspend_done_change;
        rd_word[URHP_BIT_RESET_CHG] = sts.reset_done_change;
        pready_d = psel & penable & ~pready;
        pslverr_d = pready_d & ~urhp_hit(paddr, URHP_OFS_STATUS) & ~urhp_hit(paddr, URHP_OFS_CONFIG);
        prdata_d = '0;
        if (pready_d && !pwrite)
        begin
            if (urhp_hit(paddr, URHP_OFS_STATUS))
            begin
                prdata_d = rd_word;
            end
            else if (urhp_hit(paddr, URHP_OFS_CONFIG))
            begin
                prdata_d[URHP_BIT_OC_EN] = oc_en_q;
            end
        end
    end

    // all state, frozen while the clock enable is low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= PS_IDLE;
            att_q <= 1'b0;
            oc_q <= 1'b0;
            oc_en_q <= URHP_OC_EN_RST;
            att_chg_q <= 1'b0;
            susp_chg_q <= 1'b0;
            rst_chg_q <= 1'b0;
            port_enabled <= 1'b0;
            resume_to_hc <= 1'b0;
            port_reset_drive <= 1'b0;
            port_resume_drive <= 1'b0;
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (pce)
        begin
            state_q <= state_d;
            att_q <= att_d;
            oc_q <= oc_d;
            oc_en_q <= oc_en_d;
            att_chg_q <= att_chg_d;
            susp_chg_q <= susp_chg_d;
            rst_chg_q <= rst_chg_d;
            port_enabled <= en_d;
            resume_to_hc <= wake_d;
            port_reset_drive <= rst_drv_d;
            port_resume_drive <= rsm_drv_d;
            prdata <= prdata_d;
            pready <= pready_d;
            pslverr <= pslverr_d;
        end
    end

    // checks on the sequencer and flags
    property p_reset_start;
        @(posedge pclk) disable iff (!presetn)
        pce && cmd_reset && att_q && state_q == PS_IDLE |=> port_reset_drive && sts.port_reset_active;
    endproperty
    a_reset_start: assert property (p_reset_start) else $error("reset did not start");

    property p_reset_end;
        @(posedge pclk) disable iff (!presetn)
        $rose(rst_chg_q) |-> !sts.port_reset_active && !port_reset_drive && port_enabled;
    endproperty
    a_reset_end: assert property (p_reset_end) else $error("reset status not cleared at done");

    property p_zero_write;
        @(posedge pclk) disable iff (!presetn)
        pce && sts_wr && !pwdata[URHP_BIT_RESET] && !pwdata[URHP_BIT_SUSPEND] && state_q == PS_IDLE
        |=> state_q == PS_IDLE;
    endproperty
    a_zero_write: assert property (p_zero_write) else $error("zero write started a sequence");

    property p_no_device;
        @(posedge pclk) disable iff (!presetn)
        pce && cmd_reset && !att_q |=> att_chg_q && !sts.port_reset_active;
    endproperty
    a_no_device: assert property (p_no_device) else $error("reset of empty port mishandled");

    property p_oc_follow;
        @(posedge pclk) disable iff (!presetn)
        pce |=> oc_q == ($past(oc_s) && $past(oc_en_q));
    endproperty
    a_oc_follow: assert property (p_oc_follow) else $error("overcurrent flag does not follow input");

    property p_oc_off;
        @(posedge pclk) disable iff (!presetn)
        !oc_en_q && !cfg_wr |=> !oc_q;
    endproperty
    a_oc_off: assert property (p_oc_off) else $error("overcurrent flag set while unsupported");

    property p_resume_start;
        @(posedge pclk) disable iff (!presetn)
        pce && cmd_resume && !cmd_reset && !hc_resume_state && att_q && state_q == PS_SUSPENDED
        |=> port_resume_drive && sts.port_suspended;
    endproperty
    a_resume_start: assert property (p_resume_start) else $error("resume did not start");

    property p_resume_end;
        @(posedge pclk) disable iff (!presetn)
        $rose(susp_chg_q) |-> !sts.port_suspended && !port_resume_drive;
    endproperty
    a_resume_end: assert property (p_resume_end) else $error("suspend status kept after resume");

    property p_susp_attach;
        @(posedge pclk) disable iff (!presetn)
        $rose(sts.port_suspended) |-> $past(att_q);
    endproperty
    a_susp_attach: assert property (p_susp_attach) else $error("suspend set without device");

    property p_hc_resume;
        @(posedge pclk) disable iff (!presetn)
        pce && hc_resume_state && !cmd_reset && state_q == PS_SUSPENDED |=> !sts.port_suspended;
    endproperty
    a_hc_resume: assert property (p_hc_resume) else $error("suspend kept in resume state");

    property p_wake;
        @(posedge pclk) disable iff (!presetn)
        pce && wake_s && att_q && !cmd_reset && !hc_resume_state && state_q == PS_SUSPENDED |=> resume_to_hc;
    endproperty
    a_wake: assert property (p_wake) else $error("upstream resume not passed on");

    c_reset_done: cover property (@(posedge pclk) disable iff (!presetn) $rose(rst_chg_q));
    c_resume_done: cover property (@(posedge pclk) disable iff (!presetn) $rose(susp_chg_q));
    c_wake: cover property (@(posedge pclk) disable iff (!presetn) $rose(resume_to_hc));
    c_bad_addr: cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);
endmodule

// ===== src/urhp_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module urhp_sync
    import urhp_pkg::*;
#(
    parameter int W = 1
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    if (W < 1)
    begin : g_bad_w
        $error("urhp_sync: width must be at least one");
    end

    // first stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q <= '0;
            q <= '0;
        end
        else if (pce)
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// ===== src/urhp_timer.sv
// down counter that pulses once a loaded interval has elapsed
`timescale 1ns/1ps
module urhp_timer
    import urhp_pkg::*;
#(
    parameter int W = URHP_TMR_W
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    input wire logic load,
    input wire logic [W-1:0] count,
    input wire logic stop,
    output logic expired
);
    logic [W-1:0] cnt_q, cnt_d;
    logic run_q, run_d;
    logic exp_d;

    if (W < 2)
    begin : g_bad_w
        $error("urhp_timer: width too small");
    end

    // load wins over stop; expiry after count edges
    always_comb
    begin
        cnt_d = cnt_q;
        run_d = run_q;
        exp_d = 1'b0;
        if (load)
        begin
            cnt_d = count;
            run_d = 1'b1;
        end
        else if (stop)
        begin
            run_d = 1'b0;
        end
        else if (run_q)
        begin
            if (cnt_q <= W'(1))
            begin
                run_d = 1'b0;
                exp_d = 1'b1;
            end
            else
            begin
                cnt_d = cnt_q - W'(1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= '0;
            run_q <= 1'b0;
            expired <= 1'b0;
        end
        else if (pce)
        begin
            cnt_q <= cnt_d;
            run_q <= run_d;
            expired <= exp_d;
        end
    end
endmodule
